/* logic/drive_safety_pkg.sv */
package drive_safety_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned WC_PERIOD_MS = 100;
  localparam int unsigned WC_PULSE_US = 500;
  localparam int unsigned BRAKE_PULL_MS = 200;
  // Cycle counts derived from the times and the clock rate
  localparam int unsigned WC_PERIOD_CYCLES = WC_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned WC_PULSE_CYCLES = WC_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BRAKE_PULL_CYCLES = BRAKE_PULL_MS * (CLK_HZ / 1000);
  localparam logic [1:0] WC_MISS_LIMIT = 2'h3;
  localparam int unsigned THROTTLE_QUARTER_SHIFT = 2;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [11:0] OFS_CONFIG = 12'h000;
  localparam logic [11:0] OFS_BRAKE_HOLD = 12'h004;
  localparam logic [11:0] OFS_PUSH_MAX = 12'h008;
  localparam logic [11:0] OFS_THROTTLE_MAX = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_FAULT = 12'h014;

  localparam logic [9:0] RST_CONFIG = 10'h000;
  localparam logic [7:0] RST_BRAKE_HOLD = 8'hFF;
  localparam logic [7:0] RST_PUSH_MAX = 8'h20;
  localparam logic [7:0] RST_THROTTLE_MAX = 8'hFF;

  // Emergency reverse input modes
  localparam logic [1:0] EMR_TYPE_NO = 2'h0;
  localparam logic [1:0] EMR_TYPE_NC = 2'h1;
  localparam logic [1:0] EMR_TYPE_COMP = 2'h2;

  // ==========================================================
  // Carriers
  // ==========================================================
  // Config register, bit 0 is interlock_from_switch
  typedef struct packed {
    logic mode_momentary;
    logic wc_los_enable;
    logic driver2_high_side;
    logic aux_type_wiring;
    logic driver2_aux;
    logic sro_enable;
    logic [1:0] emr_type;
    logic push_enable;
    logic interlock_from_switch;
  } cfg_t;

  // Sticky fault register, bit 0 is hpd
  typedef struct packed {
    logic sro_inhibit;
    logic param_mismatch;
    logic wiring;
    logic redundancy;
    logic high_pedal_sequence_fault;
  } faults_t;

  typedef struct packed {
    logic keyswitch;
    logic interlock_sw;
    logic forward;
    logic reverse;
    logic push;
    logic emr_no;
    logic emr_nc;
    logic mode;
  } switches_t;

  typedef struct packed {
    logic drive_enable;
    logic drive_reverse;
    logic rapid_brake;
    logic speed_limit;
    logic wake_request;
    logic limited_operating_strategy;
  } drive_out_t;

  typedef enum logic [5:0] {
    ST_REST = 6'h01,
    ST_ARMED = 6'h02,
    ST_DRIVE = 6'h04,
    ST_PUSH = 6'h08,
    ST_EMR_BRAKE = 6'h10,
    ST_EMR_DRIVE = 6'h20
  } drive_state_t;

endpackage

/* logic/drive_safety_interlock.sv */
`timescale 1ns/100ps

// Operation
// - No start until direction and throttle given
// - Inactive interlock means rest, no driving
// - Interlock on with direction/throttle: sequencing fault
// - Config picks keyswitch or switch interlock
// - Push switch releases electromagnetic brake
// - Driving inhibited until push switch off
// - Push needs enable, key, stopped, brake engaged
// - Pushed too fast: wake and limit speed
// - Emergency reverse brakes, then drives opposite
// - Config picks NO, NC or complementary sensing
// - Complementary equal states raise redundancy fault
// - NO on, NC off means reverse active
// - Reverse active at key-on inhibits driving
// - Pulse driver 2; three misses: wiring fault
// - Check without high-side driver 2: mismatch
// - Check runs only with NO and aux type
// - Config chooses limited strategy for wiring fault
// - Brake coil drops to holding level after release
// - Mode switch on selects mode 2
// - Momentary mode switch drives its indicator
module drive_safety_interlock
  import drive_safety_pkg::*;
#(
  parameter int unsigned WC_PERIOD = WC_PERIOD_CYCLES,
  parameter int unsigned WC_PULSE = WC_PULSE_CYCLES,
  parameter int unsigned BRAKE_PULL = BRAKE_PULL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire switches_t sw_pins,
  input wire logic [7:0] throttle,
  input wire logic [7:0] vehicle_speed,
  output drive_out_t drive_out,
  output logic [7:0] brake_duty,
  output logic driver2_on,
  output logic mode2_select,
  output logic mode_indicator
);

  // ==========================================================
  // Parameter checks
  // ==========================================================
  // The pulse must end inside the period or no sample is ever taken
  // The pin is seen two cycles late, so short pulses would miss
  if (WC_PULSE < 3 || WC_PULSE + 2 >= WC_PERIOD || BRAKE_PULL == 0) begin : g_bad_timing
    $error("drive_safety_interlock: illegal timing parameters");
  end

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    switches_t sw_meta;
    switches_t sw;
    logic interlock_prev;
    logic key_prev;
    drive_state_t state;
    cfg_t cfg;
    logic [7:0] hold_level;
    logic [7:0] push_max;
    logic [7:0] throttle_max;
    faults_t faults;
    logic hpd_lock;
    logic sro_lock;
    logic last_reverse;
    logic [31:0] wc_timer;
    logic [1:0] wc_misses;
    logic [31:0] brake_timer;
    logic [31:0] rdata;
  } core_t;

  // Registered state and its next copy
  core_t r;
  core_t next_r;

  // Decoded conditions and cycle events
  logic interlock;
  logic dir_on;
  logic throttle_applied;
  logic throttle_high;
  logic stopped;
  logic emr_active;
  logic emr_pair_bad;
  logic wc_config;
  logic wc_run;
  logic wc_mask;
  logic wc_sample;
  logic push_ok;
  logic runaway;
  logic drive_block;
  logic brake_released;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  faults_t fault_set;
  faults_t fault_clr;

  // ==========================================================
  // Decoded conditions
  // ==========================================================
  // Interlock source chosen by configuration
  assign interlock = r.cfg.interlock_from_switch ? r.sw.interlock_sw : r.sw.keyswitch;
  // Either direction switch selects one
  assign dir_on = r.sw.forward | r.sw.reverse;
  // Any nonzero throttle is applied
  assign throttle_applied = (throttle != 8'h00);
  // Compare throttle x4 against the maximum, i.e. a 25% threshold without a divider
  assign throttle_high = ({throttle, 2'b00} >= {2'b00, r.throttle_max});
  // Only zero speed counts as stopped
  assign stopped = (vehicle_speed == 8'h00);

  // Emergency reverse sensing per input mode
  always_comb begin
    emr_active = 1'b0;
    emr_pair_bad = 1'b0;
    unique case (r.cfg.emr_type)
      // Check pulses echo here and are no request
      EMR_TYPE_NO: emr_active = r.sw.emr_no & ~wc_mask;
      EMR_TYPE_NC: emr_active = ~r.sw.emr_nc;
      EMR_TYPE_COMP: begin
        emr_active = r.sw.emr_no & ~r.sw.emr_nc;
        emr_pair_bad = (r.sw.emr_no == r.sw.emr_nc);
      end
      // Reserved code: no reverse is ever sensed
      default: emr_active = 1'b0;
    endcase
  end

  // Wiring check only with NO sensing and driver 2 as the check's aux driver
  assign wc_config = (r.cfg.emr_type == EMR_TYPE_NO) & r.cfg.driver2_aux
                     & r.cfg.aux_type_wiring;
  // A low-side driver 2 cannot source the check current, so it never runs
  assign wc_run = wc_config & r.cfg.driver2_high_side;
  // Echo lasts two sync cycles past the pulse; a real request waits
  assign wc_mask = wc_run & (r.wc_timer < 32'(WC_PULSE + 2));
  // NO input judged in the last pulse cycle
  assign wc_sample = wc_run & (r.wc_timer == 32'(WC_PULSE - 1));

  // Push honoured only from rest with the brake still engaged
  assign brake_released = (r.state == ST_DRIVE) | (r.state == ST_EMR_DRIVE)
                          | (r.state == ST_PUSH);
  assign push_ok = r.cfg.push_enable & r.sw.push & r.sw.keyswitch & stopped
                   & ~brake_released;
  // Runaway while pushing or while switched off
  assign runaway = (vehicle_speed > r.push_max)
                   & ((r.state == ST_PUSH) | ~r.sw.keyswitch);
  // Anything that stops a normal start from rest
  assign drive_block = r.hpd_lock | r.sro_lock | r.sw.push
                       | (r.faults.wiring & ~r.cfg.wc_los_enable)
                       | r.faults.param_mismatch | emr_pair_bad;

  // APB decode
  assign wr_en = psel & penable & pwrite;
  // Reads are decoded in the setup phase
  assign rd_setup = psel & ~penable & ~pwrite;
  always_comb begin
    unique case (paddr)
      OFS_CONFIG, OFS_BRAKE_HOLD, OFS_PUSH_MAX, OFS_THROTTLE_MAX,
      OFS_STATUS, OFS_FAULT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Fault event sources
  always_comb begin
    fault_set = '0;
    fault_set.high_pedal_sequence_fault = interlock & ~r.interlock_prev
                                          & (dir_on | throttle_high);
    // Raised each cycle the contacts agree
    fault_set.redundancy = emr_pair_bad;
    fault_set.wiring = wc_sample & ~r.sw.emr_no & (r.wc_misses == WC_MISS_LIMIT - 2'h1);
    fault_set.param_mismatch = wc_config & ~r.cfg.driver2_high_side;
    fault_set.sro_inhibit = r.cfg.sro_enable & r.sw.keyswitch & ~r.key_prev
                            & emr_active;
    // Only the fault register takes clears
    fault_clr = (wr_en && paddr == OFS_FAULT) ? faults_t'(pwdata[4:0]) : '0;
  end

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    next_r = r;
    // Two-stage synchronisers for every switch pin
    next_r.sw_meta = sw_pins;
    next_r.sw = r.sw_meta;
    // Previous levels give the rising edges
    next_r.interlock_prev = interlock;
    next_r.key_prev = r.sw.keyswitch;

    // Sticky faults, write one to clear; a new event beats the clear
    next_r.faults = (r.faults & ~fault_clr) | fault_set;

    // Sequencing lock holds until the interlock is released
    if (fault_set.high_pedal_sequence_fault) begin
      next_r.hpd_lock = 1'b1;
    end else if (~interlock) begin
      next_r.hpd_lock = 1'b0;
    end
    // Reverse-at-key-on lock holds until key off
    if (fault_set.sro_inhibit) begin
      next_r.sro_lock = 1'b1;
    end else if (~r.sw.keyswitch) begin
      next_r.sro_lock = 1'b0;
    end

    // Drive permission sequencer
    unique case (r.state)
      ST_REST: begin
        // Reverse seen at key-on is refused in that same cycle
        if (emr_active & r.sw.keyswitch & ~r.sro_lock & ~fault_set.sro_inhibit) begin
          next_r.state = ST_EMR_BRAKE;
        end else if (push_ok) begin
          next_r.state = ST_PUSH;
        end else if (interlock & ~drive_block & ~fault_set.high_pedal_sequence_fault
                     & ~fault_set.sro_inhibit) begin
          next_r.state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // Start needs direction and throttle
        if (emr_active & ~r.sro_lock) begin
          next_r.state = ST_EMR_BRAKE;
        end else if (~interlock | drive_block) begin
          next_r.state = ST_REST;
        end else if (dir_on & throttle_applied) begin
          next_r.state = ST_DRIVE;
          next_r.last_reverse = r.sw.reverse;
        end
      end
      ST_DRIVE: begin
        // Direction kept for the reverse run
        if (emr_active & ~r.sro_lock) begin
          next_r.state = ST_EMR_BRAKE;
        end else if (~interlock | drive_block) begin
          next_r.state = ST_REST;
        end else if (dir_on) begin
          next_r.last_reverse = r.sw.reverse;
        end
      end
      ST_PUSH: begin
        // Leave only once the switch is off, so the brake can re-engage
        if (~r.sw.push) begin
          next_r.state = ST_REST;
        end
      end
      ST_EMR_BRAKE: begin
        // Rapid braking until stopped
        if (stopped) begin
          next_r.state = ST_EMR_DRIVE;
        end
      end
      ST_EMR_DRIVE: begin
        // Sequence ends on release; a fresh start from rest is then needed
        if (~emr_active) begin
          next_r.state = ST_REST;
        end
      end
      default: next_r.state = ST_REST;
    endcase

    // Wiring check pulse timer and miss counter
    if (~wc_run) begin
      next_r.wc_timer = '0;
      next_r.wc_misses = '0;
    end else begin
      next_r.wc_timer = (r.wc_timer == 32'(WC_PERIOD - 1)) ? 32'h0000_0000
                        : r.wc_timer + 32'h0000_0001;
      // Misses run in a row; a good one restarts
      if (wc_sample) begin
        if (r.sw.emr_no) begin
          next_r.wc_misses = '0;
        end else if (r.wc_misses != WC_MISS_LIMIT) begin
          next_r.wc_misses = r.wc_misses + 2'h1;
        end
      end
    end

    // Brake pull-in timer, held at zero while the brake is engaged and restarted each time it releases
    // It stops at the count so the hold level stands
    if (~brake_released) begin
      next_r.brake_timer = '0;
    end else if (r.brake_timer != 32'(BRAKE_PULL)) begin
      next_r.brake_timer = r.brake_timer + 32'h0000_0001;
    end

    // Register writes
    // STATUS and FAULT take no plain writes
    if (wr_en) begin
      unique case (paddr)
        OFS_CONFIG: next_r.cfg = cfg_t'(pwdata[9:0]);
        OFS_BRAKE_HOLD: next_r.hold_level = pwdata[7:0];
        OFS_PUSH_MAX: next_r.push_max = pwdata[7:0];
        OFS_THROTTLE_MAX: next_r.throttle_max = pwdata[7:0];
        default: next_r.cfg = r.cfg;
      endcase
    end

    // Read data latched in the setup phase so it leaves a flip-flop
    if (rd_setup) begin
      unique case (paddr)
        OFS_CONFIG: next_r.rdata = {22'h0, r.cfg};
        OFS_BRAKE_HOLD: next_r.rdata = {24'h0, r.hold_level};
        OFS_PUSH_MAX: next_r.rdata = {24'h0, r.push_max};
        OFS_THROTTLE_MAX: next_r.rdata = {24'h0, r.throttle_max};
        OFS_STATUS: next_r.rdata = {16'h0, r.sw, r.wc_misses, r.state};
        OFS_FAULT: next_r.rdata = {27'h0, r.faults};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Constants only; config restarts at defaults
      r <= '{sw_meta: '0, sw: '0, interlock_prev: 1'b0, key_prev: 1'b0,
             state: ST_REST, cfg: cfg_t'(RST_CONFIG), hold_level: RST_BRAKE_HOLD,
             push_max: RST_PUSH_MAX, throttle_max: RST_THROTTLE_MAX,
             faults: '0, hpd_lock: 1'b0, sro_lock: 1'b0, last_reverse: 1'b0,
             wc_timer: '0, wc_misses: '0, brake_timer: '0, rdata: '0};
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  // Read data comes straight from a flop
  assign prdata = r.rdata;

  // Drive command; reverse sequence runs against the last travel direction
  always_comb begin
    drive_out = '0;
    drive_out.drive_enable = (r.state == ST_DRIVE) | (r.state == ST_EMR_DRIVE);
    drive_out.drive_reverse = (r.state == ST_EMR_DRIVE) ? ~r.last_reverse
                              : r.last_reverse;
    drive_out.rapid_brake = (r.state == ST_EMR_BRAKE);
    // Limited strategy only when chosen
    drive_out.limited_operating_strategy = r.faults.wiring & r.cfg.wc_los_enable;
    drive_out.speed_limit = runaway | drive_out.limited_operating_strategy;
    drive_out.wake_request = runaway;
  end

  // Full coil drive to pull in, then the holding level to limit heating
  assign brake_duty = ~brake_released ? 8'h00
                      : (r.brake_timer == 32'(BRAKE_PULL)) ? r.hold_level : 8'hFF;
  // Pulse at the start of each period
  assign driver2_on = wc_run & (r.wc_timer < 32'(WC_PULSE));
  // An unconnected switch reads off, which selects mode 1
  assign mode2_select = r.sw.mode;
  // Dark unless set up as momentary
  assign mode_indicator = r.cfg.mode_momentary & r.sw.mode;

endmodule

/* testbench/vehicle_model.sv */
`timescale 1ns/100ps
module vehicle_model
  import drive_safety_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire switches_t sw_cmd,
  input wire logic wire_ok,
  input wire logic [7:0] spd_set,
  input wire drive_out_t drive_out,
  input wire logic driver2_on,
  output switches_t sw_pins,
  output logic [7:0] vehicle_speed
);
  // ==========================================
  // Operator switches, wiring and vehicle mass
  // ==========================================
  logic coast;
  // The check pulse reaches the NO input only through intact wiring
  always_comb begin
    sw_pins = sw_cmd;
    sw_pins.emr_no = sw_cmd.emr_no | (driver2_on & wire_ok);
  end
  // Braking sheds one unit a cycle; speed then stays put until the bench zeroes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vehicle_speed <= 8'h00;
      coast <= 1'b0;
    end else if (drive_out.rapid_brake) begin
      vehicle_speed <= vehicle_speed - {7'h00, |vehicle_speed};
      coast <= 1'b1;
    end else if (!coast || spd_set == 8'h00) begin
      vehicle_speed <= spd_set;
      coast <= 1'b0;
    end
  end
endmodule

/* testbench/drive_safety_monitor.sv */
`timescale 1ns/100ps
module drive_safety_monitor
  import drive_safety_pkg::*;
#(
  parameter int unsigned WC_PULSE = WC_PULSE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire switches_t sw_pins,
  input wire logic [7:0] throttle,
  input wire logic [7:0] vehicle_speed,
  input wire drive_out_t drive_out,
  input wire logic [7:0] brake_duty,
  input wire logic driver2_on,
  input wire logic mode2_select
);
  // ==========================================
  // Port relations
  // ==========================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] pulse_len;
  // Length of the running check pulse; a cut pulse would also trip the check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_len <= 32'h0;
    end else begin
      pulse_len <= driver2_on ? pulse_len + 32'h1 : 32'h0;
    end
  end
  // Switches pass two sync flops, so antecedents hold a few cycles
  no_key_rest_a: assert property (
    (!sw_pins.keyswitch && !sw_pins.interlock_sw && !sw_pins.emr_no && sw_pins.emr_nc) [*4]
    |-> !drive_out.drive_enable) else $error("drive without interlock");
  start_throttle_a: assert property (
    $rose(drive_out.drive_enable) && !$past(drive_out.rapid_brake) |-> $past(throttle) != 8'h00)
    else $error("start without throttle");
  push_inhibit_a: assert property (
    sw_pins.push [*4] |-> !drive_out.drive_enable) else $error("drive while pushing");
  reverse_stop_a: assert property (
    $fell(drive_out.rapid_brake) && drive_out.drive_enable |-> $past(vehicle_speed) == 8'h00)
    else $error("reverse before stop");
  runaway_limit_a: assert property (
    drive_out.wake_request |-> drive_out.speed_limit && vehicle_speed != 8'h00)
    else $error("wake without limit");
  brake_pullin_a: assert property (
    $rose(brake_duty != 8'h00) |-> brake_duty == 8'hFF) else $error("release without pull-in");
  check_pulse_a: assert property (
    $fell(driver2_on) |-> pulse_len == WC_PULSE) else $error("check pulse length");
  mode_follow_a: assert property (
    $stable(sw_pins.mode) [*3] |-> mode2_select == sw_pins.mode) else $error("speed mode");
  err_access_a: assert property (
    pslverr |-> psel && penable) else $error("error outside access");
endmodule

bind drive_safety_interlock drive_safety_monitor #(.WC_PULSE(WC_PULSE)) i_mon (
  .pclk, .presetn, .psel, .penable, .pslverr, .sw_pins, .throttle, .vehicle_speed,
  .drive_out, .brake_duty, .driver2_on, .mode2_select);

/* testbench/drive_safety_interlock_tb.sv */
`timescale 1ns/100ps
module drive_safety_interlock_tb;
  import drive_safety_pkg::*;
  // ==========================================
  // Bench signals; switch byte: key ilk fwd rev push no nc mode
  // ==========================================
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic wire_ok = 1'b1, pready, pslverr, d2, m2, mind, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] thr = 8'h00, spd = 8'h00, speed, bduty;
  switches_t sw = 8'h02, pins;
  drive_out_t dout;
  int n_fail = 0, checks_done = 0;
  always #2.5 pclk = ~pclk;
  // Short counts keep the wiring check and pull-in quick
  drive_safety_interlock #(.WC_PERIOD(40), .WC_PULSE(8), .BRAKE_PULL(10)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sw_pins(pins), .throttle(thr), .vehicle_speed(speed), .drive_out(dout),
    .brake_duty(bduty), .driver2_on(d2), .mode2_select(m2), .mode_indicator(mind));
  vehicle_model i_car (.pclk, .presetn, .sw_cmd(sw), .wire_ok, .spd_set(spd),
    .drive_out(dout), .driver2_on(d2), .sw_pins(pins), .vehicle_speed(speed));
  // ==========================================
  // Shared tasks
  // ==========================================
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // APB transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      finish_test();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic setsw(input logic [7:0] s, input logic [7:0] t, input logic [7:0] v);
    @(posedge pclk);
    sw <= s;
    thr <= t;
    spd <= v;
  endtask
  task automatic wait_out(input logic [5:0] m, input logic [5:0] e);
    int i;
    #1;
    for (i = 0; i < 400 && (dout & m) !== e; i++) tick(1);
    if (i >= 400) begin
      n_fail++;
      finish_test();
    end
    chk({26'h0, dout & m}, {26'h0, e});
  endtask
  // Watch for check pulses, then let a running pulse end before config changes
  task automatic d2_seen(input logic e);
    logic s;
    s = 1'b0;
    for (int i = 0; i < 45; i++) begin
      tick(1);
      s = s | d2;
    end
    for (int i = 0; i < 20 && d2 === 1'b1; i++) tick(1);
    chk(32'(s), 32'(e));
  endtask
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_drive();
    rdc(OFS_BRAKE_HOLD, 32'hFFFFFFFF, {24'h0, RST_BRAKE_HOLD});
    rdc(OFS_PUSH_MAX, 32'hFFFFFFFF, {24'h0, RST_PUSH_MAX});
    rdc(12'h020, 32'hFFFFFFFF, 32'h0);
    chk(32'(err), 32'h1);
    setsw(8'h82, 8'h00, 8'h00);
    tick(6);
    rdc(OFS_STATUS, 32'h3F, 32'h02);
    setsw(8'hA2, 8'h00, 8'h00);
    tick(6);
    chk(32'(dout.drive_enable), 32'h0);
    setsw(8'hA2, 8'h80, 8'h00);
    wait_out(6'h20, 6'h20);
    setsw(8'h22, 8'h80, 8'h00);
    wait_out(6'h20, 6'h00);
    wr(OFS_CONFIG, 32'h1);
    setsw(8'hC2, 8'h00, 8'h00);
    tick(6);
    setsw(8'hE2, 8'h80, 8'h00);
    wait_out(6'h20, 6'h20);
    setsw(8'hA2, 8'h80, 8'h00);
    wait_out(6'h20, 6'h00);
    setsw(8'h02, 8'h00, 8'h00);
    wr(OFS_CONFIG, 32'h0);
    // Just below and at a quarter of full throttle
    setsw(8'h82, 8'h3F, 8'h00);
    tick(6);
    rdc(OFS_FAULT, 32'hFFFFFFFF, 32'h0);
    setsw(8'h02, 8'h40, 8'h00);
    tick(6);
    setsw(8'h82, 8'h40, 8'h00);
    tick(6);
    rdc(OFS_FAULT, 32'hFFFFFFFF, 32'h1);
    setsw(8'h02, 8'h00, 8'h00);
    tick(6);
    wr(OFS_FAULT, 32'h1);
    rdc(OFS_FAULT, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_push();
    wr(OFS_BRAKE_HOLD, 32'h40);
    setsw(8'h8A, 8'h00, 8'h00);
    tick(6);
    chk({24'h0, bduty}, 32'h0);
    wr(OFS_CONFIG, 32'h2);
    tick(3);
    chk({24'h0, bduty}, 32'hFF);
    tick(12);
    chk({24'h0, bduty}, 32'h40);
    setsw(8'hAA, 8'h80, 8'h00);
    tick(8);
    chk(32'(dout.drive_enable), 32'h0);
    setsw(8'h82, 8'h00, 8'h00);
    tick(6);
    chk({24'h0, bduty}, 32'h0);
    setsw(8'h02, 8'h00, 8'h21);
    tick(4);
    chk(32'(dout.wake_request), 32'h1);
    setsw(8'h02, 8'h00, 8'h20);
    tick(4);
    chk(32'(dout.wake_request), 32'h0);
  endtask
  task automatic t_emr();
    logic [1:0] mode [3] = '{EMR_TYPE_NO, EMR_TYPE_NC, EMR_TYPE_COMP};
    logic [7:0] act [3] = '{8'hA4, 8'hA0, 8'hA4};
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CONFIG, {28'h0, mode[k], 2'h0});
      setsw(8'h82, 8'h00, 8'h50);
      tick(6);
      setsw(8'hA2, 8'h80, 8'h50);
      wait_out(6'h20, 6'h20);
      setsw(act[k], 8'h80, 8'h50);
      wait_out(6'h08, 6'h08);
      wait_out(6'h38, 6'h30);
      setsw(8'h02, 8'h00, 8'h00);
      tick(8);
    end
    // A clear while both contacts still agree must not stick
    setsw(8'h06, 8'h00, 8'h00);
    tick(6);
    wr(OFS_FAULT, 32'h2);
    rdc(OFS_FAULT, 32'hFFFFFFFF, 32'h2);
    setsw(8'h00, 8'h00, 8'h00);
    tick(6);
    wr(OFS_FAULT, 32'h2);
    rdc(OFS_FAULT, 32'hFFFFFFFF, 32'h2);
    setsw(8'h02, 8'h00, 8'h00);
    tick(6);
    wr(OFS_FAULT, 32'h2);
    rdc(OFS_FAULT, 32'hFFFFFFFF, 32'h0);
    wr(OFS_CONFIG, 32'h10);
    setsw(8'h84, 8'h00, 8'h00);
    tick(6);
    rdc(OFS_FAULT, 32'h10, 32'h10);
    chk({26'h0, dout & 6'h28}, 32'h0);
    setsw(8'hA2, 8'h80, 8'h00);
    tick(8);
    chk({26'h0, dout & 6'h28}, 32'h0);
    setsw(8'h02, 8'h00, 8'h00);
    tick(6);
    wr(OFS_FAULT, 32'h10);
  endtask
  task automatic t_wire();
    wr(OFS_CONFIG, 32'h60);
    tick(2);
    rdc(OFS_FAULT, 32'h8, 32'h8);
    wr(OFS_CONFIG, 32'hE0);
    d2_seen(1'b1);
    wr(OFS_FAULT, 32'h8);
    wr(OFS_CONFIG, 32'hE4);
    d2_seen(1'b0);
    @(posedge pclk);
    wire_ok <= 1'b0;
    wr(OFS_CONFIG, 32'hE0);
    tick(60);
    rdc(OFS_FAULT, 32'hFF, 32'h0);
    tick(70);
    rdc(OFS_FAULT, 32'hFF, 32'h4);
    setsw(8'h82, 8'h00, 8'h00);
    tick(6);
    setsw(8'hA2, 8'h80, 8'h00);
    tick(8);
    chk(32'(dout.drive_enable), 32'h0);
    wr(OFS_CONFIG, 32'h1E0);
    setsw(8'h82, 8'h00, 8'h00);
    tick(6);
    setsw(8'hA2, 8'h80, 8'h00);
    wait_out(6'h25, 6'h25);
    setsw(8'h02, 8'h00, 8'h00);
    d2_seen(1'b1);
    wr(OFS_CONFIG, 32'h0);
    @(posedge pclk);
    wire_ok <= 1'b1;
    wr(OFS_FAULT, 32'h4);
    setsw(8'h03, 8'h00, 8'h00);
    tick(4);
    chk({30'h0, m2, mind}, 32'h2);
    wr(OFS_CONFIG, 32'h200);
    tick(2);
    chk(32'(mind), 32'h1);
    setsw(8'h02, 8'h00, 8'h00);
    tick(4);
    chk({30'h0, m2, mind}, 32'h0);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_drive();
    t_push();
    t_emr();
    t_wire();
    finish_test();
  end
endmodule
